// ---- vsp_pkg.sv ----
// Shared constants and types for the video sync polarity, extraction and generation block
package vsp_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [2:0] OFS_COUNTER_CTRL = 3'h0;
    localparam logic [2:0] OFS_LATCH_FLAG = 3'h1;
    localparam logic [2:0] OFS_HORIZ_PERIOD = 3'h2;
    localparam logic [2:0] OFS_VERT_PERIOD = 3'h3;
    localparam logic [2:0] OFS_SYNC_CONFIG = 3'h4;
    localparam logic [2:0] OFS_OUTPUT_ENABLE = 3'h5;
    localparam logic [2:0] OFS_MUX_CTRL = 3'h6;
    localparam logic [2:0] OFS_POLARITY = 3'h7;
    // ==========================================================
    // Field positions
    localparam int CCR_MODE_LSB = 5;
    localparam int LAT_UP_BIT = 1;
    localparam int LAT_DOWN_BIT = 0;
    localparam int CFG_HGO_BIT = 7;
    localparam int CFG_VGO_BIT = 6;
    localparam int CFG_EQINH_BIT = 4;
    localparam int CFG_VERT_EXTEND_ENABLE_BIT = 3;
    localparam int ENR_SYNC_OUT_SELECT_BIT = 1;
    localparam int ENR_GEN_BIT = 0;
    localparam int MCR_FLYBACK_SOURCE_SEL_BIT = 5;
    localparam int MCR_CSEL_BIT = 4;
    localparam int POL_VCOR_BIT = 0;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_MUX_CTRL = 8'h20;
    // ==========================================================
    // Counter and timing
    localparam logic [4:0] CNT_MAX = 5'h1F;
    localparam logic [4:0] CNT_MIN = 5'h00;
    localparam int CLK_MHZ = 200;
    localparam int STEP_NS = 250;
    localparam int STEP_CYC = (STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int HPULSE_NS = 2000;
    localparam logic [7:0] HPULSE_TICKS = 8'((HPULSE_NS + STEP_NS - 1) / STEP_NS);
    localparam logic [10:0] VPULSE_LINES = 11'h004;
    localparam logic [8:0] HLOW_SAT = 9'h100;
    // ==========================================================
    // Modes and types
    typedef enum logic [1:0] {
        MODE_NORM_FALL = 2'b00,
        MODE_NORM_RISE = 2'b01,
        MODE_EXTR_NEG = 2'b10,
        MODE_EXTR_POS = 2'b11
    } vsp_mode_e;
    typedef enum logic [1:0] {
        AN_IDLE = 2'b00,
        AN_WAIT = 2'b01,
        AN_COUNT = 2'b10
    } vsp_an_e;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } vsp_bus_req_s;
endpackage : vsp_pkg

// ---- vsp_sync_proc.sv ----
// Sync polarity detector, vertical extractor, free-running generator and low-time analyzer
`timescale 1ns/10ps
`default_nettype none

module vsp_sync_proc (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire vsp_pkg::vsp_bus_req_s bus_req_i,
    output logic [7:0] rd_data_o,
    input wire logic horiz_sync_in_i,
    input wire logic composite_sync_in_i,
    input wire logic horiz_flyback_in_i,
    output logic horiz_sync_out_o,
    output logic vert_sync_out_o,
    output logic timer_capture_one_o,
    output logic timer_capture_two_o
);
    // ==========================================================
    // Registers
    logic [4:0] width_count_value;
    logic [1:0] extraction_mode_sel;
    logic up_latch_flag;
    logic down_latch_flag;
    logic [7:0] horiz_period_reg;
    logic [7:0] vert_period_reg;
    logic [7:0] sync_config_reg;
    logic [7:0] output_enable_reg;
    logic [7:0] mux_ctrl_reg;
    logic [7:0] polarity_reg;
    logic wr_ccr;
    logic wr_cfg;
    logic [10:0] vert_line_count;

    assign wr_ccr = bus_req_i.wr && (bus_req_i.addr == vsp_pkg::OFS_COUNTER_CTRL);
    assign wr_cfg = bus_req_i.wr && (bus_req_i.addr == vsp_pkg::OFS_SYNC_CONFIG);
    assign vert_line_count = {vert_period_reg, sync_config_reg[2:0]};

    // ==========================================================
    // Input synchronisers
    logic [1:0] hs_meta;
    logic [1:0] cs_meta;
    logic [1:0] fb_meta;
    logic mon;
    logic mon_d;
    logic rise_ev;
    logic fall_ev;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hs_meta <= 2'h0;
            cs_meta <= 2'h0;
            fb_meta <= 2'h0;
            mon_d <= 1'b0;
        end else begin
            hs_meta <= {hs_meta[0], horiz_sync_in_i};
            cs_meta <= {cs_meta[0], composite_sync_in_i};
            fb_meta <= {fb_meta[0], horiz_flyback_in_i};
            mon_d <= mon;
        end
    end

    assign mon = mux_ctrl_reg[vsp_pkg::MCR_CSEL_BIT] ? cs_meta[1] : hs_meta[1];
    assign rise_ev = mon && !mon_d;
    assign fall_ev = !mon && mon_d;

    // ==========================================================
    // Step timebase, 0.25 us
    logic [7:0] step_cnt;
    logic tick;

    assign tick = (step_cnt == 8'(vsp_pkg::STEP_CYC - 1));

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            step_cnt <= 8'h00;
        end else if (tick) begin
            step_cnt <= 8'h00;
        end else begin
            step_cnt <= step_cnt + 8'h01;
        end
    end

    // ==========================================================
    // Up/down counter
    logic [4:0] cnt;
    logic extr;
    logic lvl;
    logic act_edge;
    logic end_edge;

    assign extr = extraction_mode_sel[1];
    // Positive composite sync inverts the sense seen by the counter
    assign lvl = (extraction_mode_sel == vsp_pkg::MODE_EXTR_POS) ? !mon : mon;
    assign act_edge = extraction_mode_sel[0] ? rise_ev : fall_ev;
    assign end_edge = extraction_mode_sel[0] ? fall_ev : rise_ev;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= vsp_pkg::CNT_MIN;
        end else if (tick) begin
            if (lvl) begin
                if (cnt != vsp_pkg::CNT_MAX) begin
                    cnt <= cnt + 5'h01;
                end
            end else if (cnt != vsp_pkg::CNT_MIN) begin
                cnt <= cnt - 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            up_latch_flag <= 1'b0;
            down_latch_flag <= 1'b0;
        end else begin
            // Set wins over a write-one clear in the same cycle
            if (cnt == vsp_pkg::CNT_MAX) begin
                up_latch_flag <= 1'b1;
            end else if (bus_req_i.wr && bus_req_i.addr == vsp_pkg::OFS_LATCH_FLAG &&
                         bus_req_i.wdata[vsp_pkg::LAT_UP_BIT]) begin
                up_latch_flag <= 1'b0;
            end
            if (cnt == vsp_pkg::CNT_MIN) begin
                down_latch_flag <= 1'b1;
            end else if (bus_req_i.wr && bus_req_i.addr == vsp_pkg::OFS_LATCH_FLAG &&
                         bus_req_i.wdata[vsp_pkg::LAT_DOWN_BIT]) begin
                down_latch_flag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Capture and threshold measurement
    logic armed;
    logic held;
    logic in_pulse;
    logic [4:0] pw_cnt;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pw_cnt <= 5'h00;
            in_pulse <= 1'b0;
        end else if (act_edge) begin
            pw_cnt <= 5'h00;
            in_pulse <= 1'b1;
        end else if (end_edge) begin
            in_pulse <= 1'b0;
        end else if (tick && in_pulse && pw_cnt != vsp_pkg::CNT_MAX) begin
            pw_cnt <= pw_cnt + 5'h01;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            width_count_value <= vsp_pkg::CNT_MIN;
            extraction_mode_sel <= vsp_pkg::MODE_NORM_FALL;
            armed <= 1'b0;
            held <= 1'b0;
        end else if (wr_ccr) begin
            width_count_value <= bus_req_i.wdata[4:0];
            extraction_mode_sel <= bus_req_i.wdata[vsp_pkg::CCR_MODE_LSB +: 2];
            // Zero arms a width measurement; any other value is a held threshold
            armed <= (bus_req_i.wdata[4:0] == vsp_pkg::CNT_MIN);
            held <= (bus_req_i.wdata[4:0] != vsp_pkg::CNT_MIN);
        end else if (!extr) begin
            if (armed && in_pulse && end_edge) begin
                width_count_value <= pw_cnt;
                armed <= 1'b0;
                held <= 1'b1;
            end else if (!held && (rise_ev || fall_ev)) begin
                width_count_value <= cnt;
            end
        end
    end

    // ==========================================================
    // Vertical extraction, active low
    logic ext_vs_n;
    logic [4:0] thr;

    // Positive sync is inverted before the counter, so its threshold is mirrored too
    assign thr = extraction_mode_sel[0] ? ~width_count_value : width_count_value;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_vs_n <= 1'b1;
        end else if (!extr) begin
            ext_vs_n <= 1'b1;
        end else if (tick && !lvl && cnt != vsp_pkg::CNT_MIN &&
                     (cnt - 5'h01) == thr) begin
            ext_vs_n <= 1'b0;
        end else if (tick && lvl && cnt == (vsp_pkg::CNT_MAX - 5'h01)) begin
            // Short serrations cannot climb to the maximum, so they are ignored
            ext_vs_n <= 1'b1;
        end
    end

    // ==========================================================
    // Free-running generator
    logic gen_on;
    logic [7:0] hcnt;
    logic [10:0] line;
    logic gen_h;
    logic gen_v;

    assign gen_on = output_enable_reg[vsp_pkg::ENR_GEN_BIT] &&
                    !output_enable_reg[vsp_pkg::ENR_SYNC_OUT_SELECT_BIT] &&
                    !sync_config_reg[vsp_pkg::CFG_HGO_BIT] &&
                    !sync_config_reg[vsp_pkg::CFG_VGO_BIT];

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hcnt <= 8'h00;
            line <= 11'h000;
        end else if (!gen_on) begin
            hcnt <= 8'h00;
            line <= 11'h000;
        end else if (tick) begin
            if (hcnt >= horiz_period_reg) begin
                hcnt <= 8'h00;
                if (line >= vert_line_count - 11'h001) begin
                    line <= 11'h000;
                end else begin
                    line <= line + 11'h001;
                end
            end else begin
                hcnt <= hcnt + 8'h01;
            end
        end
    end

    assign gen_h = gen_on && (hcnt < vsp_pkg::HPULSE_TICKS);
    assign gen_v = gen_on && (line < vsp_pkg::VPULSE_LINES);

    // ==========================================================
    // Output drivers
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            horiz_sync_out_o <= 1'b0;
            vert_sync_out_o <= 1'b1;
            timer_capture_one_o <= 1'b1;
            timer_capture_two_o <= 1'b0;
        end else begin
            horiz_sync_out_o <= gen_on ? gen_h : mon;
            vert_sync_out_o <= gen_on ? gen_v : ext_vs_n;
            timer_capture_one_o <= ext_vs_n;
            timer_capture_two_o <= mon;
        end
    end

    // ==========================================================
    // Horizontal low-time analyzer
    vsp_pkg::vsp_an_e an_state;
    logic an_src;
    logic [8:0] low_n;
    logic an_done;
    logic [7:0] an_result;

    assign an_src = mux_ctrl_reg[vsp_pkg::MCR_FLYBACK_SOURCE_SEL_BIT] ? horiz_sync_out_o : fb_meta[1];
    assign an_done = (an_state == vsp_pkg::AN_COUNT) && (an_src || low_n == vsp_pkg::HLOW_SAT);
    assign an_result = 8'(vsp_pkg::HLOW_SAT - low_n);

    logic src_q;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            src_q <= 1'b0;
        end else begin
            src_q <= an_src;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            an_state <= vsp_pkg::AN_IDLE;
            low_n <= 9'h000;
        end else begin
            case (an_state)
                vsp_pkg::AN_IDLE: begin
                    if (sync_config_reg[vsp_pkg::CFG_HGO_BIT]) begin
                        an_state <= vsp_pkg::AN_WAIT;
                    end
                end
                vsp_pkg::AN_WAIT: begin
                    if (src_q && !an_src) begin
                        low_n <= 9'h000;
                        an_state <= vsp_pkg::AN_COUNT;
                    end
                end
                vsp_pkg::AN_COUNT: begin
                    if (an_done) begin
                        an_state <= vsp_pkg::AN_IDLE;
                    end else if (tick) begin
                        low_n <= low_n + 9'h001;
                    end
                end
                default: begin
                    an_state <= vsp_pkg::AN_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Register writes
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            horiz_period_reg <= vsp_pkg::RST_ZERO;
            sync_config_reg <= vsp_pkg::RST_ZERO;
        end else begin
            if (an_done) begin
                horiz_period_reg <= an_result;
            end else if (bus_req_i.wr && bus_req_i.addr == vsp_pkg::OFS_HORIZ_PERIOD) begin
                horiz_period_reg <= bus_req_i.wdata;
            end
            if (wr_cfg) begin
                sync_config_reg <= bus_req_i.wdata & 8'hDF;
            end
            // Hardware completion beats a software write in the same cycle
            if (an_done) begin
                sync_config_reg[vsp_pkg::CFG_HGO_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            vert_period_reg <= vsp_pkg::RST_ZERO;
            output_enable_reg <= vsp_pkg::RST_ZERO;
            mux_ctrl_reg <= vsp_pkg::RST_MUX_CTRL;
            polarity_reg <= vsp_pkg::RST_ZERO;
        end else if (bus_req_i.wr) begin
            if (bus_req_i.addr == vsp_pkg::OFS_VERT_PERIOD) begin
                vert_period_reg <= bus_req_i.wdata;
            end else if (bus_req_i.addr == vsp_pkg::OFS_OUTPUT_ENABLE) begin
                output_enable_reg <= bus_req_i.wdata & 8'h03;
            end else if (bus_req_i.addr == vsp_pkg::OFS_MUX_CTRL) begin
                mux_ctrl_reg <= bus_req_i.wdata & 8'hFE;
            end else if (bus_req_i.addr == vsp_pkg::OFS_POLARITY) begin
                polarity_reg <= bus_req_i.wdata & 8'h01;
            end
        end
    end

    // ==========================================================
    // Register reads, data one cycle after the strobe
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= 8'h00;
        end else if (!bus_req_i.rd) begin
            rd_data_o <= 8'h00;
        end else if (bus_req_i.addr == vsp_pkg::OFS_COUNTER_CTRL) begin
            rd_data_o <= {1'b0, extraction_mode_sel, width_count_value};
        end else if (bus_req_i.addr == vsp_pkg::OFS_LATCH_FLAG) begin
            rd_data_o <= {6'h00, up_latch_flag, down_latch_flag};
        end else if (bus_req_i.addr == vsp_pkg::OFS_HORIZ_PERIOD) begin
            rd_data_o <= horiz_period_reg;
        end else if (bus_req_i.addr == vsp_pkg::OFS_VERT_PERIOD) begin
            rd_data_o <= vert_period_reg;
        end else if (bus_req_i.addr == vsp_pkg::OFS_SYNC_CONFIG) begin
            rd_data_o <= sync_config_reg;
        end else if (bus_req_i.addr == vsp_pkg::OFS_OUTPUT_ENABLE) begin
            rd_data_o <= output_enable_reg;
        end else if (bus_req_i.addr == vsp_pkg::OFS_MUX_CTRL) begin
            rd_data_o <= mux_ctrl_reg;
        end else begin
            rd_data_o <= polarity_reg;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_count_up_step: assert property (tick && lvl && cnt != vsp_pkg::CNT_MAX |=>
        cnt == $past(cnt) + 5'h01) else $error("counter did not step up");
    a_count_down_step: assert property (tick && !lvl && cnt != vsp_pkg::CNT_MIN |=>
        cnt == $past(cnt) - 5'h01) else $error("counter did not step down");
    a_count_saturate: assert property (tick && lvl && cnt == vsp_pkg::CNT_MAX |=>
        cnt == vsp_pkg::CNT_MAX) else $error("counter wrapped at top");
    a_edge_capture: assert property (!extr && !held && !wr_ccr && fall_ev && !armed |=>
        width_count_value == $past(cnt)) else $error("edge capture missed");
    a_extract_assert: assert property (extr && !wr_ccr && tick && !lvl &&
        cnt != vsp_pkg::CNT_MIN && (cnt - 5'h01) == thr |=> !ext_vs_n ##1
        !timer_capture_one_o) else $error("extracted vsync not asserted");
    a_extract_negate: assert property (extr && !wr_ccr && !ext_vs_n && tick && lvl &&
        cnt == 5'h1E |=> ext_vs_n) else $error("extracted vsync not negated");
    a_hpulse_end: assert property (gen_on && $past(gen_on) && $fell(gen_h) |->
        hcnt == vsp_pkg::HPULSE_TICKS) else $error("horizontal pulse width wrong");
    a_vpulse_start: assert property (gen_on && $rose(gen_v) |-> line == 11'h000 &&
        hcnt == 8'h00) else $error("vertical pulse misaligned");
    a_measure_done: assert property (an_done |=> !sync_config_reg[vsp_pkg::CFG_HGO_BIT] &&
        horiz_period_reg == $past(an_result)) else $error("analyzer result not stored");
    a_latch_up: assert property (cnt == vsp_pkg::CNT_MAX |=> up_latch_flag)
        else $error("up latch not set");

    c_extract_pulse: cover property (extr && $fell(ext_vs_n));
    c_measure_done: cover property (an_done);
    c_gen_frame: cover property (gen_on && $rose(gen_v));
    c_threshold_held: cover property (armed ##1 held);

endmodule : vsp_sync_proc

`default_nettype wire

// ---- vsp_sync_src.sv ----
// Behavioural video sync source driving the monitored sync and flyback pins
`timescale 1ns/10ps
`default_nettype none
module vsp_sync_src (
    input wire logic ref_clk_i,
    input wire logic idle_i,
    output logic sync_o,
    output logic flyback_o
);
    // ==========================================================
    // Pulse generation
    logic active = 1'b0;
    // Lines carry sync pulses only, so a pulse is simply the inverse of the idle level
    assign sync_o = idle_i ^ active;
    assign flyback_o = idle_i ^ active;
    task automatic pulse(input int ticks);
        @(posedge ref_clk_i);
        active <= 1'b1;
        repeat (ticks * vsp_pkg::STEP_CYC) @(posedge ref_clk_i);
        active <= 1'b0;
    endtask : pulse
endmodule : vsp_sync_src
`default_nettype wire

// ---- vsp_sync_proc_tb.sv ----
// Self-checking testbench for the sync polarity, extraction and generation block
`timescale 1ns/10ps
`default_nettype none
module vsp_sync_proc_tb;
    // ==========================================================
    // Clock, reset and wiring
    localparam int T = vsp_pkg::STEP_CYC;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic idle = 1'b1;
    vsp_pkg::vsp_bus_req_s bus = '0;
    logic [7:0] rd_data;
    logic [7:0] d;
    logic sync, flyback, hs_out, vs_out, cap_one, cap_two;
    logic [31:0] seed = 32'h54FB;
    int err_count = 0;
    int compares = 0;
    int hi, per, p, n;
    initial forever #2.5 ref_clk_i = ~ref_clk_i;
    vsp_sync_src i_vsp_sync_src (.ref_clk_i(ref_clk_i), .idle_i(idle), .sync_o(sync),
        .flyback_o(flyback));
    vsp_sync_proc i_vsp_sync_proc (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_req_i(bus),
        .rd_data_o(rd_data), .horiz_sync_in_i(sync), .composite_sync_in_i(sync),
        .horiz_flyback_in_i(flyback), .horiz_sync_out_o(hs_out), .vert_sync_out_o(vs_out),
        .timer_capture_one_o(cap_one), .timer_capture_two_o(cap_two));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk_i);
        #1;
    endtask : tick
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_i);
        bus <= '0;
        #1;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge ref_clk_i);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_i);
        bus <= '0;
        #1;
        d = rd_data;
    endtask : rd
    task automatic fail(input logic [31:0] g, input logic [31:0] e);
        err_count++;
        $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
    endtask : fail
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) fail(g, e);
    endtask : chk8
    // Tick phase against the pin edge leaves one step of slack in measured widths
    task automatic chk_near(input logic [7:0] g, input int e);
        compares++;
        if (^g === 1'bx || int'(g) > e + 1 || int'(g) < e - 1) fail(g, e);
    endtask : chk_near
    task automatic chk_cyc(input int g, input int e);
        compares++;
        if (g != e) fail(g, e);
    endtask : chk_cyc
    function automatic logic probe(input bit v);
        return v ? vs_out : hs_out;
    endfunction : probe
    task automatic meas(input bit v);
        int k;
        for (k = 0; probe(v) !== 1'b0 && k < 40000; k++) tick(1);
        for (k = 0; probe(v) !== 1'b1 && k < 40000; k++) tick(1);
        for (hi = 0; probe(v) === 1'b1 && hi < 40000; hi++) tick(1);
        for (per = hi; probe(v) === 1'b0 && per < 80000; per++) tick(1);
    endtask : meas
    task automatic end_of_test();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    // ==========================================================
    // Scenarios
    initial begin
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a));
            // The counter rests at zero after reset, so the down latch is already set
            chk8(d, (a == 6) ? vsp_pkg::RST_MUX_CTRL : (a == 1) ? 8'h01 : vsp_pkg::RST_ZERO);
        end
        wr(vsp_pkg::OFS_MUX_CTRL, 8'h10);
        tick(40 * T);
        chk8({7'h00, cap_two}, 8'h01);
        fork i_vsp_sync_src.pulse(8); join_none
        tick(4 * T);
        chk8({7'h00, cap_two}, 8'h00);
        rd(vsp_pkg::OFS_COUNTER_CTRL);
        chk8({3'b000, d[4:0]}, {3'b000, vsp_pkg::CNT_MAX});
        tick(8 * T);
        @(posedge ref_clk_i) idle <= 1'b0;
        tick(40 * T);
        wr(vsp_pkg::OFS_COUNTER_CTRL, 8'h00);
        // Positive pulses need the rising-edge mode to measure the high time
        wr(vsp_pkg::OFS_COUNTER_CTRL, 8'h20);
        fork i_vsp_sync_src.pulse(4); join_none
        tick(6 * T);
        rd(vsp_pkg::OFS_COUNTER_CTRL);
        chk_near({3'b000, d[4:0]}, 4);
        rd(vsp_pkg::OFS_LATCH_FLAG);
        chk8(d, 8'h03);
        wr(vsp_pkg::OFS_LATCH_FLAG, 8'h03);
        rd(vsp_pkg::OFS_LATCH_FLAG);
        chk8(d, 8'h00);
        wr(vsp_pkg::OFS_MUX_CTRL, 8'h00);
        @(posedge ref_clk_i) idle <= 1'b1;
        tick(40 * T);
        wr(vsp_pkg::OFS_COUNTER_CTRL, 8'h40);
        i_vsp_sync_src.pulse(4);
        tick(4 * T);
        chk8({7'h00, vs_out}, 8'h01);
        fork i_vsp_sync_src.pulse(60); join_none
        tick(38 * T);
        chk8({7'h00, vs_out}, 8'h00);
        chk8({7'h00, cap_one}, 8'h00);
        @(posedge ref_clk_i) idle <= 1'b0;
        tick(4 * T);
        @(posedge ref_clk_i) idle <= 1'b1;
        tick(4 * T);
        chk8({7'h00, vs_out}, 8'h00);
        tick(16 * T);
        chk8({7'h00, vs_out}, 8'h00);
        tick(34 * T);
        chk8({7'h00, vs_out}, 8'h01);
        chk8({7'h00, cap_one}, 8'h01);
        // Positive composite sync: idle low, long high vertical interval
        @(posedge ref_clk_i) idle <= 1'b0;
        wr(vsp_pkg::OFS_COUNTER_CTRL, 8'h7F);
        tick(40 * T);
        fork i_vsp_sync_src.pulse(40); join_none
        tick(38 * T);
        chk8({7'h00, vs_out}, 8'h00);
        tick(40 * T);
        chk8({7'h00, vs_out}, 8'h01);
        @(posedge ref_clk_i) idle <= 1'b1;
        p = 8 + int'(rnd() % 16);
        wr(vsp_pkg::OFS_HORIZ_PERIOD, 8'(p));
        wr(vsp_pkg::OFS_VERT_PERIOD, 8'h01);
        wr(vsp_pkg::OFS_SYNC_CONFIG, 8'h05);
        wr(vsp_pkg::OFS_POLARITY, 8'h01);
        wr(vsp_pkg::OFS_OUTPUT_ENABLE, 8'h01);
        meas(1'b0);
        chk_cyc(hi, int'(vsp_pkg::HPULSE_TICKS) * T);
        chk_cyc(per, (p + 1) * T);
        meas(1'b1);
        chk_cyc(hi, 4 * (p + 1) * T);
        chk_cyc(per, 13 * (p + 1) * T);
        wr(vsp_pkg::OFS_OUTPUT_ENABLE, 8'h00);
        // Second pass runs past the 64 us ceiling to reach saturation
        for (int i = 0; i < 2; i++) begin
            n = (i == 0) ? 1 + int'(rnd() % 200) : 270;
            wr(vsp_pkg::OFS_SYNC_CONFIG, 8'h80);
            fork i_vsp_sync_src.pulse(n); join_none
            for (int k = 0; k < 300; k++) begin
                rd(vsp_pkg::OFS_SYNC_CONFIG);
                if (d[7] === 1'b0) break;
                tick(100);
            end
            chk8({7'h00, d[7]}, 8'h00);
            rd(vsp_pkg::OFS_HORIZ_PERIOD);
            chk_near(d, (n > 256) ? 0 : 256 - n);
        end
        end_of_test();
    end
    initial begin
        // Longest path is about 72000 cycles; two frames of the slowest generated video take about 31200 of them
        repeat (95000) @(posedge ref_clk_i);
        err_count++;
        end_of_test();
    end
endmodule : vsp_sync_proc_tb
`default_nettype wire
